/* rtl/gbp_pkg.sv */
// ---------------------------------------------------------------------------
// Shared constants of the baseband port timing block.
// ---------------------------------------------------------------------------
package gbp_pkg;

  // All times below are counted in master clock periods, not in mclk cycles.
  localparam int unsigned TX_WAKE_TICKS  = 24;  // Wake delay before the first bit clock edge.
  localparam int unsigned TX_HALF_TICKS  = 24;  // Length of each bit clock phase.
  localparam int unsigned TX_LAST_WINDOW = 23;  // Sleep request window after a bit clock edge.
  localparam int unsigned RX_WORD_BITS   = 12;  // Bits in one receive word.
  localparam int unsigned RX_PAIR_BITS   = 24;  // Bits in one in-phase and quadrature pair.
  localparam int unsigned RX_PAIR_WORD_RATE_LOW  = 48;  // Pair period at the low word rate.
  localparam int unsigned RX_PAIR_WORD_RATE_HIGH  = 24;  // Pair period at the high word rate.
  localparam int unsigned AUX_BITS       = 16;  // Length of the auxiliary shift register.

  // Synchroniser lane positions of the pin inputs.
  localparam int unsigned SY_MCK1   = 0;
  localparam int unsigned SY_MCK2   = 1;
  localparam int unsigned SY_TXSLP  = 2;
  localparam int unsigned SY_TXDAT  = 3;
  localparam int unsigned SY_RXSLP  = 4;
  localparam int unsigned SY_ASCLK  = 5;
  localparam int unsigned SY_ADAT   = 6;
  localparam int unsigned SY_ALAT   = 7;
  localparam int unsigned SY_MODE   = 8;
  localparam int unsigned SY_RATE   = 9;
  localparam int unsigned SY_WIDTH  = 10;

  // Values after reset.
  localparam logic [9:0]  SYNC_RST  = 10'h000;
  localparam logic [5:0]  CNT_RST   = 6'h00;
  localparam logic [15:0] AUX_RST   = 16'h0000;
  localparam logic [23:0] SHIFT_RST = 24'h00_0000;

  // Transmit bit clock sequencer states.
  typedef enum logic [3:0] {
    GBP_TX_SLEEP = 4'b0001,
    GBP_TX_WAKE  = 4'b0010,
    GBP_TX_HIGH  = 4'b0100,
    GBP_TX_LOW   = 4'b1000
  } gbp_tx_state_type;

endpackage : gbp_pkg

/* rtl/gbp_rx_if.sv */
`timescale 1ns/10ps
// ---------------------------------------------------------------------------
// Carrier between the port top and the receive word serialiser.
// ---------------------------------------------------------------------------
interface gbp_rx_if;
  logic        tick;        // One pulse per master clock two period.
  logic        mode;        // Output mode, 0 single pin, 1 split pins.
  logic        rate;        // Word rate select, 0 low, 1 high.
  logic        awake;       // Receive path out of sleep.
  logic [11:0] i_word;      // In-phase word from the converter.
  logic [11:0] q_word;      // Quadrature word from the converter.
  logic        word_taken;  // Pulse when a pair is loaded.
  logic        ser_out;     // Single pin serial data.
  logic        iq_sel;      // High while the single pin carries in-phase bits.
  logic        i_out;       // Split in-phase data pin.
  logic        q_out;       // Split quadrature data pin.
  logic        frame_sync;  // Marks the first bit of a pair.
  logic        bit_clk;     // Receive bit clock.

  modport top (output tick, mode, rate, awake, i_word, q_word,
               input word_taken, ser_out, iq_sel, i_out, q_out, frame_sync, bit_clk);
  modport ser (input tick, mode, rate, awake, i_word, q_word,
               output word_taken, ser_out, iq_sel, i_out, q_out, frame_sync, bit_clk);
endinterface : gbp_rx_if

/* rtl/gbp_rx_ser.sv */
`timescale 1ns/10ps
// ---------------------------------------------------------------------------
// Receive word serialiser: one bit per master period, pin set by mode.
// ---------------------------------------------------------------------------
module gbp_rx_ser
  import gbp_pkg::*;
(
  input  wire logic mclk,
  input  wire logic sys_rst,
  gbp_rx_if.ser     rx
);

  logic [5:0]  cnt_ff,  nxt_cnt;     // Master periods into the pair period.
  logic [23:0] sh_ff,   nxt_sh;      // Pair shift register, in-phase in the top half.
  logic        ser_ff,  nxt_ser;
  logic        iqs_ff,  nxt_iqs;
  logic        io_ff,   nxt_io;
  logic        qo_ff,   nxt_qo;
  logic        fs_ff,   nxt_fs;
  logic        bc_ff,   nxt_bc;
  logic        tk_ff,   nxt_tk;
  logic [5:0]  period;               // Pair period for the chosen rate.

  // Pair period follows the rate select; the high rate halves it.
  assign period = rx.rate ? 6'(RX_PAIR_WORD_RATE_HIGH) : 6'(RX_PAIR_WORD_RATE_LOW);

  // ---------------------------------------------------------------------------
  // Next state: load a pair at period start, then shift one bit per tick.
  // ---------------------------------------------------------------------------
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_sh  = sh_ff;
    nxt_ser = ser_ff;
    nxt_iqs = iqs_ff;
    nxt_io  = io_ff;
    nxt_qo  = qo_ff;
    nxt_fs  = 1'b0;
    nxt_bc  = 1'b0;
    nxt_tk  = 1'b0;
    if (!rx.awake) begin
      // Sleeping: pins park low and the next wake starts a fresh pair.
      nxt_cnt = CNT_RST;
      nxt_sh  = SHIFT_RST;
      nxt_ser = 1'b0;
      nxt_iqs = 1'b0;
      nxt_io  = 1'b0;
      nxt_qo  = 1'b0;
    end else if (rx.tick) begin
      nxt_bc  = 1'b1;
      nxt_cnt = (cnt_ff == period - 6'd1) ? CNT_RST : cnt_ff + 6'd1;
      if (cnt_ff == CNT_RST) begin
        // A new pair starts; its first bit goes out now.
        nxt_sh = {rx.i_word, rx.q_word};
        nxt_fs = 1'b1;
        nxt_tk = 1'b1;
      end else begin
        nxt_sh = {sh_ff[22:0], 1'b0};
      end
      if (!rx.mode) begin
        // Mode 0: one pin carries 24 bits, in-phase first.
        nxt_ser = (cnt_ff < 6'(RX_PAIR_BITS)) ? nxt_sh[23] : 1'b0;
        nxt_iqs = cnt_ff < 6'(RX_WORD_BITS);
        nxt_io  = 1'b0;
        nxt_qo  = 1'b0;
      end else begin
        // Mode 1: two pins carry 12 bits each in parallel.
        nxt_ser = 1'b0;
        nxt_iqs = 1'b0;
        nxt_io  = (cnt_ff < 6'(RX_WORD_BITS)) ? nxt_sh[23] : 1'b0;
        nxt_qo  = (cnt_ff < 6'(RX_WORD_BITS)) ? nxt_sh[11] : 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Registers.
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff <= CNT_RST;
      sh_ff  <= SHIFT_RST;
      ser_ff <= 1'b0;
      iqs_ff <= 1'b0;
      io_ff  <= 1'b0;
      qo_ff  <= 1'b0;
      fs_ff  <= 1'b0;
      bc_ff  <= 1'b0;
      tk_ff  <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      sh_ff  <= nxt_sh;
      ser_ff <= nxt_ser;
      iqs_ff <= nxt_iqs;
      io_ff  <= nxt_io;
      qo_ff  <= nxt_qo;
      fs_ff  <= nxt_fs;
      bc_ff  <= nxt_bc;
      tk_ff  <= nxt_tk;
    end
  end

  assign rx.ser_out    = ser_ff;
  assign rx.iq_sel     = iqs_ff;
  assign rx.i_out      = io_ff;
  assign rx.q_out      = qo_ff;
  assign rx.frame_sync = fs_ff;
  assign rx.bit_clk    = bc_ff;
  assign rx.word_taken = tk_ff;

  // The single pin and its in-phase marker stay quiet in mode 1.
  a_mode_pin_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
    (rx.mode && $stable(rx.mode)) |=> (!ser_ff && !iqs_ff))
    else $error("single pin active in split mode");

  // Check helper: ticks since the last pair start, counted apart from cnt_ff
  // so that a broken period counter cannot hide behind its own value.
  logic [5:0] gap_ff;      // Ticks since the last pair start.
  logic       fs_seen_ff;  // A pair has started since the last wake.

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      gap_ff     <= CNT_RST;
      fs_seen_ff <= 1'b0;
    end else if (!rx.awake) begin
      gap_ff     <= CNT_RST;
      fs_seen_ff <= 1'b0;
    end else if (rx.tick) begin
      gap_ff     <= nxt_fs ? CNT_RST : gap_ff + 6'd1;
      fs_seen_ff <= fs_seen_ff | nxt_fs;
    end
  end

  // A pair restarts exactly one pair period after the previous one.
  a_pair_period: assert property (@(posedge mclk) disable iff (sys_rst)
    (nxt_fs && fs_seen_ff && $stable(rx.rate)) |-> (gap_ff == period - 6'd1))
    else $error("frame sync off the pair boundary");

endmodule : gbp_rx_ser

/* rtl/gbp_port.sv */
`timescale 1ns/10ps
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
module gbp_port
  import gbp_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        master_clock_one,    // Transmit master clock pin.
  input  wire logic        master_clock_two,    // Receive master clock pin.
  input  wire logic        tx_sleep_req,        // Transmit sleep request pin.
  input  wire logic        tx_data_in,          // Transmit data bit pin.
  input  wire logic        rx_sleep_req,        // Receive sleep request pin.
  input  wire logic        out_mode_sel,        // Output mode pin.
  input  wire logic        word_rate_sel,       // Word rate select pin.
  input  wire logic        aux_sclk,            // Auxiliary serial clock pin.
  input  wire logic        aux_sdata,           // Auxiliary serial data pin.
  input  wire logic        aux_latch,           // Auxiliary latch strobe pin.
  input  wire logic [11:0] rx_i_conv,           // In-phase word from the converter.
  input  wire logic [11:0] rx_q_conv,           // Quadrature word from the converter.
  output logic             tx_bit_clk,          // Transmit bit clock pin.
  output logic             tx_bit,              // Captured transmit bit.
  output logic             tx_bit_stb,          // Pulse when tx_bit is new.
  output logic             rx_serial_data,      // Mode 0 receive data pin.
  output logic             rx_iq_flag,          // Mode 0 in-phase marker.
  output logic             in_phase_word_out,   // Mode 1 in-phase data pin.
  output logic             quadrature_word_out, // Mode 1 quadrature data pin.
  output logic             rx_frame_sync,       // Receive frame sync pin.
  output logic             rx_bit_clk,          // Receive bit clock pin.
  output logic             rx_word_taken,       // Pulse when a pair is loaded.
  output logic             aux_flag             // Auxiliary flag pin.
);

  // ---------------------------------------------------------------------------
  // Pin synchronisers: two stages, then a third stage for edge detection.
  // ---------------------------------------------------------------------------
  logic [9:0] s1_ff, s2_ff, s3_ff;   // Only s2 and s3 feed logic.
  logic       mck1_tick;             // Rising edge of master clock one.
  logic       mck2_tick;             // Rising edge of master clock two.
  logic       sclk_fall;             // Falling edge of the auxiliary clock.
  logic       latch_rise;            // Rising edge of the auxiliary latch.

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_ff <= SYNC_RST;
      s2_ff <= SYNC_RST;
      s3_ff <= SYNC_RST;
    end else begin
      s1_ff <= {word_rate_sel, out_mode_sel, aux_latch, aux_sdata, aux_sclk,
                rx_sleep_req, tx_data_in, tx_sleep_req, master_clock_two,
                master_clock_one};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  assign mck1_tick  = s2_ff[SY_MCK1] & ~s3_ff[SY_MCK1];
  assign mck2_tick  = s2_ff[SY_MCK2] & ~s3_ff[SY_MCK2];
  assign sclk_fall  = ~s2_ff[SY_ASCLK] & s3_ff[SY_ASCLK];
  assign latch_rise = s2_ff[SY_ALAT] & ~s3_ff[SY_ALAT];

  // ---------------------------------------------------------------------------
  // Transmit bit clock sequencer.
  // ---------------------------------------------------------------------------
  gbp_tx_state_type st_ff, nxt_st;
  logic [5:0] cnt_ff,  nxt_cnt;      // Master periods into the current phase.
  logic       last_ff, nxt_last;     // Current bit clock cycle is the final one.
  logic       clk_ff,  nxt_clk;
  logic       bit_ff,  nxt_bit;
  logic       stb_ff,  nxt_stb;
  logic       sleep_s;

  assign sleep_s = s2_ff[SY_TXSLP];

  // Next state. A sleep request seen during a cycle is latched so that a
  // short pulse still ends the bit stream at the cycle boundary; the flag
  // is cleared only in the sleep state, where it is never set.
  always_comb begin
    nxt_st   = st_ff;
    nxt_cnt  = cnt_ff;
    nxt_last = last_ff;
    nxt_clk  = clk_ff;
    nxt_bit  = bit_ff;
    nxt_stb  = 1'b0;
    unique case (st_ff)
      GBP_TX_SLEEP: begin
        // Clock held low while asleep.
        nxt_clk  = 1'b0;
        nxt_last = 1'b0;
        if (!sleep_s && mck1_tick) begin
          // First master edge after release starts the wake count.
          nxt_st  = GBP_TX_WAKE;
          nxt_cnt = CNT_RST;
        end
      end
      GBP_TX_WAKE: begin
        if (sleep_s) begin
          nxt_st = GBP_TX_SLEEP;
        end else if (mck1_tick) begin
          if (cnt_ff == 6'(TX_WAKE_TICKS - 1)) begin
            nxt_st  = GBP_TX_HIGH;
            nxt_clk = 1'b1;
            nxt_cnt = CNT_RST;
          end else begin
            nxt_cnt = cnt_ff + 6'd1;
          end
        end
      end
      GBP_TX_HIGH: begin
        if (sleep_s) begin
          nxt_last = 1'b1;
        end
        if (mck1_tick) begin
          if (cnt_ff == 6'(TX_HALF_TICKS - 1)) begin
            // Falling edge: the data bit is captured here.
            nxt_st  = GBP_TX_LOW;
            nxt_clk = 1'b0;
            nxt_cnt = CNT_RST;
            nxt_bit = s2_ff[SY_TXDAT];
            nxt_stb = 1'b1;
          end else begin
            nxt_cnt = cnt_ff + 6'd1;
          end
        end
      end
      GBP_TX_LOW: begin
        if (sleep_s) begin
          nxt_last = 1'b1;
        end
        if (mck1_tick) begin
          if (cnt_ff == 6'(TX_HALF_TICKS - 1)) begin
            nxt_cnt = CNT_RST;
            if (last_ff || sleep_s) begin
              nxt_st = GBP_TX_SLEEP;
            end else begin
              nxt_st  = GBP_TX_HIGH;
              nxt_clk = 1'b1;
            end
          end else begin
            nxt_cnt = cnt_ff + 6'd1;
          end
        end
      end
      default: begin
        nxt_st  = GBP_TX_SLEEP;
        nxt_clk = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff   <= GBP_TX_SLEEP;
      cnt_ff  <= CNT_RST;
      last_ff <= 1'b0;
      clk_ff  <= 1'b0;
      bit_ff  <= 1'b0;
      stb_ff  <= 1'b0;
    end else begin
      st_ff   <= nxt_st;
      cnt_ff  <= nxt_cnt;
      last_ff <= nxt_last;
      clk_ff  <= nxt_clk;
      bit_ff  <= nxt_bit;
      stb_ff  <= nxt_stb;
    end
  end

  assign tx_bit_clk = clk_ff;
  assign tx_bit     = bit_ff;
  assign tx_bit_stb = stb_ff;

  // ---------------------------------------------------------------------------
  // Auxiliary serial load and flag latch.
  // ---------------------------------------------------------------------------
  logic [15:0] aux_sh_ff, nxt_aux_sh;   // Bits shifted in on the clock fall.
  logic        flag_ff,   nxt_flag;

  // The flag takes the oldest loaded bit; later words do not move it until
  // the latch strobe rises again.
  always_comb begin
    nxt_aux_sh = aux_sh_ff;
    nxt_flag   = flag_ff;
    if (sclk_fall) begin
      nxt_aux_sh = {aux_sh_ff[14:0], s2_ff[SY_ADAT]};
    end
    if (latch_rise) begin
      nxt_flag = aux_sh_ff[AUX_BITS-1];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      aux_sh_ff <= AUX_RST;
      flag_ff   <= 1'b0;
    end else begin
      aux_sh_ff <= nxt_aux_sh;
      flag_ff   <= nxt_flag;
    end
  end

  assign aux_flag = flag_ff;

  // ---------------------------------------------------------------------------
  // Receive path. Words after wake are sent as produced; discarding the
  // unsettled ones is left to the partner, which keeps this side simple.
  // ---------------------------------------------------------------------------
  gbp_rx_if rx_bus ();

  assign rx_bus.tick   = mck2_tick;
  assign rx_bus.mode   = s2_ff[SY_MODE];
  assign rx_bus.rate   = s2_ff[SY_RATE];
  assign rx_bus.awake  = ~s2_ff[SY_RXSLP];
  assign rx_bus.i_word = rx_i_conv;
  assign rx_bus.q_word = rx_q_conv;

  gbp_rx_ser u_rx_ser (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .rx      (rx_bus.ser)
  );

  assign rx_serial_data      = rx_bus.ser_out;
  assign rx_iq_flag          = rx_bus.iq_sel;
  assign in_phase_word_out   = rx_bus.i_out;
  assign quadrature_word_out = rx_bus.q_out;
  assign rx_frame_sync       = rx_bus.frame_sync;
  assign rx_bit_clk          = rx_bus.bit_clk;
  assign rx_word_taken       = rx_bus.word_taken;

  // ---------------------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------------------
  logic [5:0] hi_ticks_ff;   // Master edges seen while the bit clock is high.

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      hi_ticks_ff <= CNT_RST;
    end else if (!clk_ff) begin
      hi_ticks_ff <= CNT_RST;
    end else if (mck1_tick) begin
      hi_ticks_ff <= hi_ticks_ff + 6'd1;
    end
  end

  a_wake_first_edge: assert property (@(posedge mclk) disable iff (sys_rst)
    ($rose(clk_ff) && $past(st_ff) == GBP_TX_WAKE) |-> $past(cnt_ff) == 6'd23)
    else $error("bit clock started at the wrong wake count");

  a_high_phase_len: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(clk_ff) |-> (hi_ticks_ff == 6'(TX_HALF_TICKS)))
    else $error("bit clock high phase not 24 master periods");

  a_last_cycle: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(clk_ff) |-> !$past(last_ff))
    else $error("bit clock ran on after its final cycle");

  a_capture_fall: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(clk_ff) |-> (stb_ff && bit_ff == $past(s2_ff[SY_TXDAT])))
    else $error("transmit bit not taken on the bit clock fall");

  a_sleep_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_ff == GBP_TX_SLEEP) |=> !clk_ff)
    else $error("bit clock active during sleep");

  a_aux_flag_upd: assert property (@(posedge mclk) disable iff (sys_rst)
    latch_rise |=> (flag_ff == $past(aux_sh_ff[AUX_BITS-1])))
    else $error("auxiliary flag not updated by the latch strobe");

endmodule : gbp_port

/* dv/gbp_dsp_model.sv */
`timescale 1ns/10ps
// ---------------------------------------------------------------------------
// Baseband processor model: master clocks, sleep pins and transmit bits.
// ---------------------------------------------------------------------------
module gbp_dsp_model (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic tx_sleep_cmd,      // Bench asks for transmit sleep.
  input  wire logic rx_sleep_cmd,      // Bench asks for receive sleep.
  input  wire logic tx_bit_clk,
  input  wire logic rx_frame_sync,
  output logic      master_clock_one,
  output logic      master_clock_two,
  output logic      tx_sleep_req,
  output logic      tx_data_in,
  output logic      rx_sleep_req,
  output logic      rx_settled         // High once receive words are useful.
);
  logic [3:0] div_ff;    // Master period divider, ten mclk cycles.
  logic       bclk_ff;   // Last seen bit clock level.
  logic [7:0] pat_ff;    // Rotating transmit pattern.
  logic [1:0] settle_ff; // Frame syncs seen since wake.

  // Pins move by non-blocking assignment on the mclk rise, so the block's
  // synchroniser always sees them settled a full cycle later.
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      div_ff           <= 4'h0;
      master_clock_one <= 1'b0;
      master_clock_two <= 1'b0;
      tx_sleep_req     <= 1'b1;
      rx_sleep_req     <= 1'b0;
      bclk_ff          <= 1'b0;
      pat_ff           <= 8'hb2;
      settle_ff        <= 2'h0;
    end else begin
      div_ff           <= (div_ff == 4'h9) ? 4'h0 : div_ff + 4'h1;
      master_clock_one <= (div_ff == 4'h9) || (div_ff < 4'h4);
      master_clock_two <= (div_ff == 4'h9) || (div_ff < 4'h4);
      if (div_ff == 4'h4) begin
        tx_sleep_req <= tx_sleep_cmd;
      end
      // Receive sleep goes up only just after a frame sync.
      if (rx_frame_sync && rx_sleep_cmd) begin
        rx_sleep_req <= 1'b1;
      end else if (!rx_sleep_cmd && div_ff == 4'h4) begin
        rx_sleep_req <= 1'b0;
      end
      bclk_ff <= tx_bit_clk;
      // New bit on the rise, so it stands across the capturing fall.
      if (tx_bit_clk && !bclk_ff) begin
        pat_ff <= {pat_ff[6:0], pat_ff[7]};
      end
      // Words after wake are ignored until two pairs have passed.
      if (rx_sleep_req) begin
        settle_ff <= 2'h0;
      end else if (rx_frame_sync && settle_ff != 2'h2) begin
        settle_ff <= settle_ff + 2'h1;
      end
    end
  end

  assign tx_data_in = pat_ff[7];
  assign rx_settled = (settle_ff == 2'h2);
endmodule : gbp_dsp_model

/* dv/gbp_port_bench.sv */
`timescale 1ns/10ps
// ---------------------------------------------------------------------------
// Self-checking bench of the baseband port.
// ---------------------------------------------------------------------------
module gbp_port_bench;
  import gbp_pkg::*;
  localparam int LIMIT = 60000;  // Cycle ceiling, well above the run length.
  logic        mclk, sys_rst, tx_sleep_cmd, rx_sleep_cmd;
  logic        out_mode_sel, word_rate_sel, aux_sclk, aux_sdata, aux_latch;
  logic        master_clock_one, master_clock_two, tx_sleep_req, tx_data_in;
  logic        rx_sleep_req, rx_settled, tx_bit_clk, tx_bit, tx_bit_stb;
  logic        rx_serial_data, rx_iq_flag, in_phase_word_out, quadrature_word_out;
  logic        rx_frame_sync, rx_bit_clk, rx_word_taken, aux_flag;
  logic [11:0] rx_i_conv, rx_q_conv;
  int          bad_count, checked, cyc;

  gbp_dsp_model i_gbp_dsp_model (.mclk(mclk), .sys_rst(sys_rst),
    .tx_sleep_cmd(tx_sleep_cmd), .rx_sleep_cmd(rx_sleep_cmd), .tx_bit_clk(tx_bit_clk),
    .rx_frame_sync(rx_frame_sync), .master_clock_one(master_clock_one),
    .master_clock_two(master_clock_two), .tx_sleep_req(tx_sleep_req),
    .tx_data_in(tx_data_in), .rx_sleep_req(rx_sleep_req), .rx_settled(rx_settled));

  gbp_port i_gbp_port (.mclk(mclk), .sys_rst(sys_rst),
    .master_clock_one(master_clock_one), .master_clock_two(master_clock_two),
    .tx_sleep_req(tx_sleep_req), .tx_data_in(tx_data_in), .rx_sleep_req(rx_sleep_req),
    .out_mode_sel(out_mode_sel), .word_rate_sel(word_rate_sel), .aux_sclk(aux_sclk),
    .aux_sdata(aux_sdata), .aux_latch(aux_latch), .rx_i_conv(rx_i_conv),
    .rx_q_conv(rx_q_conv), .tx_bit_clk(tx_bit_clk), .tx_bit(tx_bit),
    .tx_bit_stb(tx_bit_stb), .rx_serial_data(rx_serial_data), .rx_iq_flag(rx_iq_flag),
    .in_phase_word_out(in_phase_word_out), .quadrature_word_out(quadrature_word_out),
    .rx_frame_sync(rx_frame_sync), .rx_bit_clk(rx_bit_clk),
    .rx_word_taken(rx_word_taken), .aux_flag(aux_flag));

  // Free running 125 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // A hang is counted as a mismatch and closes the run.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      bad_count++;
      summarize();
    end
  end

  // Inputs change one nanosecond after the edge, outputs are settled by then.
  task automatic step();
    @(posedge mclk);
    #1;
  endtask : step

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Release sleep, count master rises to the first bit clock rise, then phases.
  task automatic t_wake();
    int n;
    logic prev;
    n = 0;
    tx_sleep_cmd = 1'b0;
    while (tx_sleep_req !== 1'b0 && n < 40) begin
      step();
      n++;
    end
    n = 0;
    prev = master_clock_one;
    while (tx_bit_clk !== 1'b1 && n < 60) begin
      step();
      if (master_clock_one && !prev) n++;
      prev = master_clock_one;
    end
    check(n, 25);
    n = 0;
    while (tx_bit_clk === 1'b1 && n < 600) begin
      step();
      n++;
    end
    check(n, 240);
    n = 0;
    while (tx_bit_clk === 1'b0 && n < 600) begin
      step();
      n++;
    end
    check(n, 240);
  endtask : t_wake

  // Each capture strobe sits on the bit clock fall and holds the offered bit.
  task automatic t_bits();
    int n;
    repeat (4) begin
      n = 0;
      while (tx_bit_stb !== 1'b1 && n < 600) begin
        step();
        n++;
      end
      check(tx_bit, tx_data_in);
      check(tx_bit_clk, 1'b0);
      step();
    end
  endtask : t_bits

  // Sleep d master periods into a cycle: that cycle ends, then nothing runs.
  task automatic t_sleep(input int d);
    int n, stb, rises;
    logic prev;
    n = 0;
    prev = 1'b1;
    while (!(tx_bit_clk === 1'b1 && !prev) && n < 600) begin
      prev = tx_bit_clk;
      step();
      n++;
    end
    for (n = 0; n < d; n++) begin
      @(posedge master_clock_one);
    end
    step();
    tx_sleep_cmd = 1'b1;
    stb = 0;
    rises = 0;
    prev = tx_bit_clk;
    repeat (1500) begin
      step();
      stb += tx_bit_stb;
      if (tx_bit_clk && !prev) rises++;
      prev = tx_bit_clk;
    end
    check(stb, 1);
    check(rises, 0);
    check(tx_bit_clk, 0);
  endtask : t_sleep

  // Sleep the receiver, pick mode and rate, wake, skip settling, read a pair.
  task automatic t_rx(input logic md, input logic rt, input int span);
    int n, k, t0;
    logic [23:0] s;
    rx_sleep_cmd = 1'b1;
    n = 0;
    while (rx_sleep_req !== 1'b1 && n < 600) begin
      step();
      n++;
    end
    k = 0;
    repeat (300) begin
      step();
      k += rx_frame_sync;
    end
    check(k, 0);
    out_mode_sel = md;
    word_rate_sel = rt;
    rx_sleep_cmd = 1'b0;
    n = 0;
    while (!(rx_settled && rx_frame_sync) && n < 3000) begin
      step();
      n++;
    end
    t0 = cyc;
    check(rx_word_taken, 1'b1);
    s = 24'h00_0000;
    for (k = 0; k < (md ? 12 : 24); k++) begin
      if (k > 0) begin
        n = 0;
        do begin
          step();
          n++;
        end while (rx_bit_clk !== 1'b1 && n < 30);
      end
      if (md) s = {s[21:0], in_phase_word_out, quadrature_word_out};
      else s = {s[22:0], rx_serial_data};
      if (!md) check(rx_iq_flag, k < 12);
    end
    if (md) begin
      for (k = 0; k < 12; k++) begin
        check({s[2*k+1], s[2*k]}, {rx_i_conv[k], rx_q_conv[k]});
      end
    end else begin
      check(s, {rx_i_conv, rx_q_conv});
    end
    n = 0;
    do begin
      step();
      n++;
    end while (rx_frame_sync !== 1'b1 && n < 600);
    check(cyc - t0, span);
  endtask : t_rx

  // Shift a word oldest bit first; only the latch strobe moves the flag.
  task automatic t_aux(input logic [15:0] w, input logic old);
    for (int i = 15; i >= 0; i--) begin
      aux_sdata = w[i];
      aux_sclk = 1'b1;
      repeat (4) step();
      aux_sclk = 1'b0;
      repeat (4) step();
    end
    check(aux_flag, old);
    aux_latch = 1'b1;
    repeat (8) step();
    check(aux_flag, w[15]);
    aux_latch = 1'b0;
    step();
  endtask : t_aux

  task automatic summarize();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize

  // Main sequence.
  initial begin
    bad_count = 0;
    checked = 0;
    cyc = 0;
    sys_rst = 1'b1;
    tx_sleep_cmd = 1'b1;
    rx_sleep_cmd = 1'b0;
    out_mode_sel = 1'b0;
    word_rate_sel = 1'b0;
    aux_sclk = 1'b0;
    aux_sdata = 1'b0;
    aux_latch = 1'b0;
    rx_i_conv = 12'ha5c;
    rx_q_conv = 12'h3c6;
    repeat (8) @(posedge mclk);
    #1;
    check({tx_bit_clk, tx_bit_stb, rx_frame_sync, aux_flag}, 0);
    sys_rst = 1'b0;
    t_wake();
    t_bits();
    t_sleep(0);
    t_wake();
    t_sleep(22);
    t_wake();
    t_rx(1'b0, 1'b0, 480);
    t_rx(1'b0, 1'b1, 240);
    t_rx(1'b1, 1'b0, 480);
    t_rx(1'b1, 1'b1, 240);
    t_aux(16'h8001, 1'b0);
    t_aux(16'h7fff, 1'b1);
    summarize();
  end
endmodule : gbp_port_bench
